// [core/fmc_pkg.sv]
package fmc_pkg;

  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned LOW_TONE_HZ   = 1200;
  localparam int unsigned HIGH_TONE_HZ  = 2200;
  localparam int unsigned STEPS_COARSE  = 32;
  localparam int unsigned STEPS_FINE    = 128;
  localparam int unsigned ACC_W         = 26;
  localparam int unsigned INCR_W        = 19;

  localparam logic [7:0]  ADDR_CFG_IDX    = 8'h0e;
  localparam logic [7:0]  ADDR_STATUS_IDX = 8'h0d;
  localparam logic [15:0] CFG_RESET       = 16'h0040;
  localparam logic [1:0]  CFG_RSVD_ZERO   = 2'h0;
  localparam logic [13:0] MIDCODE         = 14'h2000;
  localparam logic [5:0]  AMP_BASE        = 6'h10;
  localparam logic [6:0]  STEP_FINE_INC   = 7'h01;
  localparam logic [6:0]  STEP_COARSE_INC = 7'h04;

  typedef struct packed {
    logic       highToneOnly;
    logic [1:0] reserved;
    logic       externalLoopbackSel;
    logic       rxHighOrderFilterEn;
    logic       rxExternalFilterEn;
    logic       txWaveResolution;
    logic [4:0] txAmplitudeCode;
    logic       modemEnable;
    logic       internalLoopbackEn;
    logic       txBufferHizIdle;
    logic       requestToSend;
  } fmc_cfg_t;

  typedef enum logic [1:0] {
    RX_FROM_LINE,
    RX_FROM_INTERNAL,
    RX_FROM_EXT_FILTER
  } fmc_rx_path_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [9:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } fmc_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } fmc_wb_rsp_t;

endpackage : fmc_pkg

// [core/fmc_step_gen.sv]
`timescale 1ns/1ps
`default_nettype none
// Emits one-cycle step pulses at an average rate of stepRate Hz with no drift.
module fmc_step_gen #(
  parameter int unsigned CLK_HZ = fmc_pkg::CLK_HZ
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // Rate control
  input  wire logic                       run,
  input  wire logic [fmc_pkg::INCR_W-1:0] stepRate,
  // Step enable
  output logic                            stepPulse
);

  typedef struct packed {
    logic [fmc_pkg::ACC_W-1:0] acc;
    logic                      pulse;
  } fmc_step_state_t;

  localparam logic [fmc_pkg::ACC_W-1:0] LIMIT = fmc_pkg::ACC_W'(CLK_HZ);

  fmc_step_state_t st_ff;
  fmc_step_state_t nxt_st;

  always_comb begin
    logic [fmc_pkg::ACC_W-1:0] sum;
    sum = st_ff.acc + fmc_pkg::ACC_W'(stepRate);
    nxt_st = st_ff;
    nxt_st.pulse = 1'b0;
    if (!run) begin
      nxt_st.acc = '0;
    end else if (sum >= LIMIT) begin
      nxt_st.acc   = sum - LIMIT;
      nxt_st.pulse = 1'b1;
    end else begin
      nxt_st.acc = sum;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign stepPulse = st_ff.pulse;

endmodule : fmc_step_gen
`default_nettype wire

// [core/fmc_sine_rom.sv]
`timescale 1ns/1ps
`default_nettype none
// Quarter-wave sine table folded to a 128-step period, registered read.
module fmc_sine_rom (
  // Clock
  input  wire logic              clk,
  // Read port
  input  wire logic [6:0]        phase,
  output logic signed [7:0]      sample
);

  localparam logic [7:0] TABLE [32] = '{
    8'h00, 8'h06, 8'h0c, 8'h13, 8'h19, 8'h1f, 8'h25, 8'h2b,
    8'h31, 8'h36, 8'h3c, 8'h41, 8'h47, 8'h4c, 8'h51, 8'h55,
    8'h5a, 8'h5e, 8'h62, 8'h66, 8'h6a, 8'h6d, 8'h70, 8'h73,
    8'h75, 8'h78, 8'h7a, 8'h7b, 8'h7d, 8'h7e, 8'h7f, 8'h7f};

  logic signed [7:0] sample_ff;
  logic signed [7:0] nxt_sample;

  always_comb begin
    logic [4:0] idx;
    logic [7:0] mag;
    idx = phase[5] ? ~phase[4:0] : phase[4:0];
    mag = TABLE[idx];
    nxt_sample = phase[6] ? -$signed(mag) : $signed(mag);
  end

  always_ff @(posedge clk) begin
    sample_ff <= nxt_sample;
  end

  assign sample = sample_ff;

endmodule : fmc_sine_rom
`default_nettype wire

// [core/fmc_modem_cfg.sv]
// Our own choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module fmc_modem_cfg (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Register bus
  input  wire fmc_pkg::fmc_wb_req_t  wbReq,
  output fmc_pkg::fmc_wb_rsp_t       wbRsp,
  // Modem datapath status
  input  wire logic                  carrierDetect,
  input  wire logic                  txFifoEmpty,
  input  wire logic                  txBit,
  // Transmit output buffer
  output logic [13:0]                modulatorOutputPin,
  output logic                       modulatorOutputEn,
  // Receive and transmit control
  output logic                       txEnable,
  output logic                       rxEnable,
  output logic                       rxHighOrderFilterEn,
  output fmc_pkg::fmc_rx_path_t      receivePath,
  output logic                       externalLoopbackSel
);

  typedef struct packed {
    fmc_pkg::fmc_cfg_t     cfg;
    logic                  ack;
    logic [31:0]           rdat;
    logic                  txActive;
    logic [6:0]            phase;
    logic [13:0]           sample;
    logic                  outEn;
    fmc_pkg::fmc_rx_path_t rxPath;
  } fmc_cfg_state_t;

  localparam logic [15:0] STEP_COARSE_LOW  = 16'(fmc_pkg::LOW_TONE_HZ * fmc_pkg::STEPS_COARSE);
  localparam logic [15:0] STEP_FINE_LOW_HI = 16'h0;
  localparam logic [fmc_pkg::INCR_W-1:0] RATE_LO_C =
    fmc_pkg::INCR_W'(fmc_pkg::LOW_TONE_HZ * fmc_pkg::STEPS_COARSE);
  localparam logic [fmc_pkg::INCR_W-1:0] RATE_HI_C =
    fmc_pkg::INCR_W'(fmc_pkg::HIGH_TONE_HZ * fmc_pkg::STEPS_COARSE);
  localparam logic [fmc_pkg::INCR_W-1:0] RATE_LO_F =
    fmc_pkg::INCR_W'(fmc_pkg::LOW_TONE_HZ * fmc_pkg::STEPS_FINE);
  localparam logic [fmc_pkg::INCR_W-1:0] RATE_HI_F =
    fmc_pkg::INCR_W'(fmc_pkg::HIGH_TONE_HZ * fmc_pkg::STEPS_FINE);

  fmc_cfg_state_t              st_ff;
  fmc_cfg_state_t              nxt_st;
  logic                        toneHigh;
  logic [fmc_pkg::INCR_W-1:0]  stepRate;
  logic                        stepPulse;
  logic signed [7:0]           romData;
  logic signed [14:0]          product;
  logic [7:0]                  regIdx;
  logic                        busReq;
  logic                        cfgWrite;

  assign busReq   = wbReq.cyc & wbReq.stb;
  assign regIdx   = wbReq.adr[9:2];
  assign cfgWrite = st_ff.ack & busReq & wbReq.we & (regIdx == fmc_pkg::ADDR_CFG_IDX);

  // Space tone when real FIFO data carries a zero or highToneOnly is set; otherwise an empty FIFO idles on mark.
  always_comb begin
    toneHigh = st_ff.cfg.highToneOnly | (~txFifoEmpty & ~txBit);
    case ({st_ff.cfg.txWaveResolution, toneHigh})
      2'b00:   stepRate = RATE_LO_C;
      2'b01:   stepRate = RATE_HI_C;
      2'b10:   stepRate = RATE_LO_F;
      default: stepRate = RATE_HI_F;
    endcase
  end

  fmc_step_gen #(
    .CLK_HZ    (fmc_pkg::CLK_HZ)
  ) u_step (
    .clk       (clk),
    .rst       (rst),
    .run       (st_ff.txActive),
    .stepRate  (stepRate),
    .stepPulse (stepPulse)
  );

  fmc_sine_rom u_rom (
    .clk    (clk),
    .phase  (st_ff.phase),
    .sample (romData)
  );

  // Amplitude scale of 16 + code gives 25 mVpp per code on a 400 mVpp base.
  assign product = romData * $signed({1'b0, fmc_pkg::AMP_BASE + {1'b0, st_ff.cfg.txAmplitudeCode}});

  always_comb begin
    logic signed [14:0] level;
    logic [15:0]        wrVal;
    level  = $signed({1'b0, fmc_pkg::MIDCODE}) + product;
    wrVal  = st_ff.cfg;
    nxt_st = st_ff;

    // Classic Wishbone: ack one cycle after the strobe, dropped the cycle after.
    nxt_st.ack = busReq & ~st_ff.ack;
    if (busReq & ~st_ff.ack & ~wbReq.we) begin
      case (regIdx)
        fmc_pkg::ADDR_CFG_IDX:    nxt_st.rdat = {16'h0000, st_ff.cfg};
        fmc_pkg::ADDR_STATUS_IDX: nxt_st.rdat = {29'h0, toneHigh, carrierDetect, st_ff.txActive};
        default:                  nxt_st.rdat = 32'h0000_0000;
      endcase
    end else begin
      nxt_st.rdat = 32'h0000_0000;
    end

    if (cfgWrite) begin
      if (wbReq.sel[0]) begin
        wrVal[7:0] = wbReq.dat[7:0];
      end
      if (wbReq.sel[1]) begin
        wrVal[15:8] = wbReq.dat[15:8];
      end
      nxt_st.cfg          = wrVal;
      nxt_st.cfg.reserved = fmc_pkg::CFG_RSVD_ZERO;
    end

    // Modulation starts only with no carrier on the line, then holds until released.
    nxt_st.txActive = st_ff.cfg.modemEnable & st_ff.cfg.requestToSend
                    & (st_ff.txActive | ~carrierDetect);

    if (!st_ff.txActive) begin
      nxt_st.phase = 7'h00;
    end else if (stepPulse) begin
      nxt_st.phase = st_ff.phase + (st_ff.cfg.txWaveResolution ? fmc_pkg::STEP_FINE_INC
                                                              : fmc_pkg::STEP_COARSE_INC);
    end

    nxt_st.sample = st_ff.txActive ? level[13:0] : fmc_pkg::MIDCODE;
    nxt_st.outEn  = st_ff.txActive | ~st_ff.cfg.txBufferHizIdle;

    if (st_ff.cfg.rxExternalFilterEn) begin
      nxt_st.rxPath = fmc_pkg::RX_FROM_EXT_FILTER;
    end else if (st_ff.cfg.internalLoopbackEn & ~st_ff.cfg.externalLoopbackSel) begin
      nxt_st.rxPath = fmc_pkg::RX_FROM_INTERNAL;
    end else begin
      nxt_st.rxPath = fmc_pkg::RX_FROM_LINE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff        <= '0;
      st_ff.cfg    <= fmc_pkg::CFG_RESET;
      st_ff.sample <= fmc_pkg::MIDCODE;
      st_ff.outEn  <= 1'b1;
      st_ff.rxPath <= fmc_pkg::RX_FROM_LINE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wbRsp.ack           = st_ff.ack;
  assign wbRsp.dat           = st_ff.rdat;
  assign modulatorOutputPin  = st_ff.sample;
  assign modulatorOutputEn   = st_ff.outEn;
  assign txEnable            = st_ff.cfg.modemEnable;
  assign rxEnable            = st_ff.cfg.modemEnable;
  assign rxHighOrderFilterEn = st_ff.cfg.rxHighOrderFilterEn;
  assign externalLoopbackSel = st_ff.cfg.externalLoopbackSel;
  assign receivePath         = st_ff.rxPath;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence cfgWriteSeq;
    cfgWrite && wbReq.sel[1];
  endsequence

  sequence cfgReadAck;
    st_ff.ack && busReq && !wbReq.we && regIdx == fmc_pkg::ADDR_CFG_IDX;
  endsequence

  sequence idleTwo;
    !st_ff.txActive [*2];
  endsequence

  chk_tone_only: assert property (
    st_ff.cfg.highToneOnly && st_ff.txActive |->
      (stepRate == RATE_HI_C || stepRate == RATE_HI_F))
    else $error("tone-only mode did not select the high tone");

  chk_idle_carrier: assert property (
    st_ff.txActive && txFifoEmpty && !st_ff.cfg.highToneOnly |->
      (stepRate == RATE_LO_C || stepRate == RATE_LO_F))
    else $error("empty FIFO did not give the low carrier");

  chk_ext_duplex: assert property (
    st_ff.cfg.externalLoopbackSel && !st_ff.cfg.rxExternalFilterEn |=>
      receivePath == fmc_pkg::RX_FROM_LINE)
    else $error("external duplex did not take receive from the line");

  chk_high_filter: assert property (
    cfgWriteSeq |=> rxHighOrderFilterEn == $past(wbReq.dat[11]))
    else $error("filter order bit did not follow the write");

  chk_ext_filter: assert property (
    st_ff.cfg.rxExternalFilterEn |=> receivePath == fmc_pkg::RX_FROM_EXT_FILTER)
    else $error("external filter not selected");

  chk_coarse_step: assert property (
    st_ff.txActive && stepPulse && !st_ff.cfg.txWaveResolution && nxt_st.txActive |=>
      st_ff.phase == $past(st_ff.phase) + 7'h04)
    else $error("coarse waveform did not advance four table steps");

  chk_fine_step: assert property (
    st_ff.txActive && stepPulse && st_ff.cfg.txWaveResolution && nxt_st.txActive |=>
      st_ff.phase == $past(st_ff.phase) + 7'h01)
    else $error("fine waveform did not advance one table step");

  chk_amp_peak: assert property (
    st_ff.txActive && romData == 8'sh7f && st_ff.cfg.txAmplitudeCode == 5'h00 |=>
      modulatorOutputPin == 14'h27f0)
    else $error("amplitude code zero gave the wrong peak");

  chk_enable_off: assert property (
    !st_ff.cfg.modemEnable && !cfgWrite |=> !st_ff.txActive && !rxEnable && !txEnable)
    else $error("disabled modem still active");

  chk_int_loop: assert property (
    st_ff.cfg.internalLoopbackEn && !st_ff.cfg.externalLoopbackSel
      && !st_ff.cfg.rxExternalFilterEn |=> receivePath == fmc_pkg::RX_FROM_INTERNAL)
    else $error("internal loopback not selected");

  chk_idle_buffer: assert property (
    idleTwo |-> modulatorOutputPin == fmc_pkg::MIDCODE
      && modulatorOutputEn == !$past(st_ff.cfg.txBufferHizIdle))
    else $error("idle transmit buffer in the wrong state");

  chk_rts_start: assert property (
    $rose(st_ff.txActive) |-> $past(!carrierDetect) && $past(st_ff.cfg.requestToSend))
    else $error("modulation started with carrier present");

  chk_rsvd_zero: assert property (
    cfgReadAck |-> wbRsp.dat[14:13] == 2'b00)
    else $error("reserved bits read nonzero");

endmodule : fmc_modem_cfg
`default_nettype wire

// [test/fmc_loop_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fmc_loop_model (
  // Clock
  input  wire logic clk,
  // Line state from the bench
  input  wire logic carrierOn,
  // Modem datapath status
  output logic      carrierDetect,
  output logic      txFifoEmpty,
  output logic      txBit
);
  // The FIFO is never filled, so a request to send must give the bare carrier.
  // The FIFO level trips are never touched here, so no change happens while enabled.
  initial begin
    carrierDetect = 1'b0;
    txFifoEmpty   = 1'b1;
    txBit         = 1'b0;
  end
  always @(posedge clk) begin
    carrierDetect <= carrierOn;
    txFifoEmpty   <= 1'b1;
    // The bit changes every cycle so that a design that heeds it is seen.
    txBit         <= ~txBit;
  end
endmodule : fmc_loop_model
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                  clk;
  logic                  rst;
  logic                  carrierOn;
  fmc_pkg::fmc_wb_req_t  req;
  fmc_pkg::fmc_wb_rsp_t  rsp;
  logic                  carrierDetect;
  logic                  txFifoEmpty;
  logic                  txBit;
  logic [13:0]           modulatorOutputPin;
  logic                  modulatorOutputEn;
  logic                  txEnable;
  logic                  rxEnable;
  logic                  rxHighOrderFilterEn;
  logic                  externalLoopbackSel;
  fmc_pkg::fmc_rx_path_t receivePath;
  logic [31:0]           rd;
  int                    error_cnt;
  int                    comparisons;
  int                    cycleCnt;
  int                    ch;
  logic [13:0]           mx;

  fmc_modem_cfg DUT (
    .clk(clk), .rst(rst), .wbReq(req), .wbRsp(rsp),
    .carrierDetect(carrierDetect), .txFifoEmpty(txFifoEmpty), .txBit(txBit),
    .modulatorOutputPin(modulatorOutputPin), .modulatorOutputEn(modulatorOutputEn),
    .txEnable(txEnable), .rxEnable(rxEnable),
    .rxHighOrderFilterEn(rxHighOrderFilterEn), .receivePath(receivePath),
    .externalLoopbackSel(externalLoopbackSel)
  );

  fmc_loop_model loop (
    .clk(clk), .carrierOn(carrierOn), .carrierDetect(carrierDetect),
    .txFifoEmpty(txFifoEmpty), .txBit(txBit)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task final_report;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  // The run is about 45000 cycles; the ceiling leaves a wide margin.
  always @(posedge clk) begin
    cycleCnt <= cycleCnt + 1;
    if (cycleCnt == 95000) begin
      error_cnt = error_cnt + 1;
      final_report();
    end
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task rng(input int v, input int lo, input int hi);
    chk({31'h0, v >= lo && v <= hi}, 32'h1);
  endtask : rng

  task automatic wb(input logic we, input logic [9:0] a, input logic [15:0] d);
    int n;
    @(posedge clk);
    req <= {1'b1, 1'b1, we, a, 4'h3, 16'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.ack !== 1'b1 && n < 20);
    rd = rsp.dat;
    req <= '0;
    if (n >= 20) chk(32'h1, 32'h0);
    repeat (3) @(posedge clk);
  endtask : wb

  task automatic watch(input int n);
    logic [13:0] last;
    ch = 0;
    mx = 14'h0000;
    last = modulatorOutputPin;
    repeat (n) begin
      @(posedge clk);
      if (modulatorOutputPin !== last) ch++;
      if (modulatorOutputPin > mx) mx = modulatorOutputPin;
      last = modulatorOutputPin;
    end
  endtask : watch

  task t_reset;
    wb(1'b0, 10'h038, 16'h0000);
    chk(rd, 32'h00000040);
    chk({31'h0, modulatorOutputEn}, 32'h1);
    chk({18'h0, modulatorOutputPin}, 32'h00002000);
    chk({30'h0, txEnable, rxEnable}, 32'h0);
  endtask : t_reset

  task t_fields;
    wb(1'b1, 10'h038, 16'hfffe);
    wb(1'b0, 10'h038, 16'h0000);
    chk(rd, 32'h00009ffe);
    chk({31'h0, externalLoopbackSel}, 32'h1);
    chk({31'h0, rxHighOrderFilterEn}, 32'h1);
    chk({30'h0, receivePath}, {30'h0, fmc_pkg::RX_FROM_EXT_FILTER});
    chk({30'h0, txEnable, rxEnable}, 32'h3);
    wb(1'b1, 10'h038, 16'h0006);
    chk({30'h0, receivePath}, {30'h0, fmc_pkg::RX_FROM_INTERNAL});
    chk({31'h0, externalLoopbackSel}, 32'h0);
    chk({31'h0, modulatorOutputEn}, 32'h0);
    chk({30'h0, txEnable, rxEnable}, 32'h0);
    wb(1'b1, 10'h038, 16'h0040);
    chk({30'h0, receivePath}, {30'h0, fmc_pkg::RX_FROM_LINE});
    chk({31'h0, modulatorOutputEn}, 32'h1);
    wb(1'b0, 10'h03c, 16'h0000);
    chk(rd, 32'h0);
  endtask : t_fields

  // Carrier on the line holds the request back; once it drops the low tone runs.
  task t_carrier;
    carrierOn <= 1'b1;
    wb(1'b1, 10'h038, 16'h0009);
    watch(2000);
    chk(ch, 0);
    chk({18'h0, modulatorOutputPin}, 32'h00002000);
    carrierOn <= 1'b0;
    watch(17000);
    rng(ch, 31, 34);
    chk({18'h0, mx}, 32'h000027f0);
  endtask : t_carrier

  task t_tone;
    wb(1'b1, 10'h038, 16'h81f9);
    wb(1'b0, 10'h034, 16'h0000);
    chk(rd & 32'h4, 32'h4);
    watch(13020);
    rng(ch, 45, 47);
    chk({18'h0, mx}, 32'h00003751);
  endtask : t_tone

  // Fine steps may repeat a code near the peaks, so only a band is asked.
  task t_fine;
    wb(1'b1, 10'h038, 16'h0249);
    watch(13020);
    rng(ch, 60, 101);
    wb(1'b1, 10'h038, 16'h0048);
    chk({18'h0, modulatorOutputPin}, 32'h00002000);
    chk({31'h0, modulatorOutputEn}, 32'h1);
  endtask : t_fine

  initial begin
    rst = 1'b1;
    carrierOn = 1'b0;
    req = '0;
    error_cnt = 0;
    comparisons = 0;
    cycleCnt = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_fields();
    t_carrier();
    t_tone();
    t_fine();
    final_report();
  end
endmodule : tb
`default_nettype wire
